// ===== dv/tb.sv
// Purpose: Self-checking bench for the timer core.
// Assumes: Clock select 1 ticks on every edge while it is set.
// Notes:   Seeded random counts, compare values and output modes.
`timescale 1ns/10ps
`default_nettype none
`include "tmr_defs.svh"
module tb
  import tmr_pkg::*;
;
  logic       ref_clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  tmr_bus_s   bus = '0;
  logic [2:0] ack = 3'h0;
  logic       pin_en = 1'b0;
  logic       pin;
  logic [7:0] rdata;
  logic [2:0] irq;
  logic       oca;
  logic       ocb;
  logic [7:0] v, c, r;
  logic [2:0] iq;
  logic [1:0] m;
  logic       oa, ob, o, o2, ov;
  int         failures = 0;
  int         total_checks = 0;
  int         cyc = 0;
  int         n;
  integer     seed = 32'h1a6d;

  always #10 ref_clk_i = ~ref_clk_i;

  tmr_core i_tmr_core (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .bus_i(bus),
    .external_count_pin_i(pin), .irq_ack_i(ack), .rdata_o(rdata),
    .irq_o(irq), .compare_output_a_o(oca), .compare_output_b_o(ocb));

  tmr_pin_model i_tmr_pin_model (
    .ref_clk_i(ref_clk_i), .en_i(pin_en), .pin_o(pin));

  // Expected output state after k matches under output mode md.
  function automatic logic exp_oc(logic s, logic [1:0] md, int k);
    if (k == 0 || md == 2'h0) return s;
    if (md == 2'h1) return s ^ k[0];
    return md[0];
  endfunction

  // Tick period for each clock select code; the pin edge comes every 8.
  function automatic int div(int s);
    case (s)
      1: return 1;
      3: return 64;
      4: return 256;
      5: return 1024;
      default: return 8;
    endcase
  endfunction

  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk_i);
  endtask

  task automatic idle(input int k);
    bus.wr <= 1'b0;
    bus.rd <= 1'b0;
    repeat (k) @(posedge ref_clk_i);
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk_i);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
    oa = oca;
    ob = ocb;
    iq = irq;
    @(posedge ref_clk_i);
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bus_rd(a, d);
    chk(d, exp);
  endtask

  // Runs the counter for k clock cycles (k at least 2), then stops it.
  task automatic run(input logic [7:0] b, input int k);
    bus_wr(`TMR_ADR_CTLB, b);
    idle(k - 1);
    bus_wr(`TMR_ADR_CTLB, {b[7:3], 3'h0});
    idle(1);
  endtask

  // Cuts a hang short.
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      wrap_up();
    end
  end

  // Main sequence.
  initial begin
    repeat (20) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    for (int i = 0; i < 8; i++) begin
      rchk(i[2:0], 8'h00);
    end
    v = 8'($random(seed));
    bus_wr(`TMR_ADR_COUNT, v);
    idle(5);
    rchk(`TMR_ADR_COUNT, v);
    // Normal mode runs from random counts; overflow expected only across the wrap point.
    bus_wr(`TMR_ADR_MASK, 8'h01);
    repeat (8) begin
      v = 8'($random(seed));
      n = 2 + ($random(seed) & 31);
      ov = (int'(v) + n) > 255;
      bus_wr(`TMR_ADR_FLAGS, 8'h07);
      bus_wr(`TMR_ADR_COUNT, v);
      run(8'h01, n);
      rchk(`TMR_ADR_COUNT, v + n[7:0]);
      bus_wr(`TMR_ADR_FLAGS, 8'h00);
      bus_rd(`TMR_ADR_FLAGS, r);
      chk(r[0], ov);
      chk(iq[0], ov);
      ack <= 3'h7;
      @(posedge ref_clk_i);
      ack <= 3'h0;
      rchk(`TMR_ADR_FLAGS, 8'h00);
    end
    // Clear on match with random output modes.
    repeat (8) begin
      c = 8'(3 + ($random(seed) & 15));
      n = 2 + ($random(seed) & 63);
      m = 2'($random(seed));
      bus_wr(`TMR_ADR_CTLA, {m, 4'h0, 2'h2});
      bus_wr(`TMR_ADR_CMPA, c);
      bus_wr(`TMR_ADR_COUNT, 8'h00);
      bus_wr(`TMR_ADR_FLAGS, 8'h07);
      bus_rd(`TMR_ADR_FLAGS, r);
      o = oa;
      run(8'h01, n);
      rchk(`TMR_ADR_COUNT, 8'(n % (c + 1)));
      chk(oa, exp_oc(o, m, n / (c + 1)));
      bus_rd(`TMR_ADR_FLAGS, r);
      chk(r[1], n > c);
    end
    // Force strobes in normal mode, every output mode twice.
    for (int i = 0; i < 8; i++) begin
      m = i[1:0];
      bus_wr(`TMR_ADR_CTLA, {m, m, 4'h0});
      bus_wr(`TMR_ADR_FLAGS, 8'h07);
      bus_rd(`TMR_ADR_COUNT, v);
      o = oa;
      o2 = ob;
      bus_wr(`TMR_ADR_CTLC, 8'hc0);
      rchk(`TMR_ADR_COUNT, v);
      chk({oa, ob}, {exp_oc(o, m, 1), exp_oc(o2, m, 1)});
      rchk(`TMR_ADR_FLAGS, 8'h00);
      rchk(`TMR_ADR_CTLC, 8'h00);
    end
    // A count write hides a match only in the next tick.
    bus_wr(`TMR_ADR_CTLA, 8'h00);
    for (int i = 0; i < 2; i++) begin
      v = 8'h10 + 8'($random(seed) & 63);
      bus_wr(`TMR_ADR_CMPA, v);
      bus_wr(`TMR_ADR_COUNT, v - i[7:0]);
      bus_wr(`TMR_ADR_FLAGS, 8'h07);
      run(8'h01, 2);
      bus_rd(`TMR_ADR_FLAGS, r);
      chk(r[1], i[0]);
      chk(iq[1], 1'b0);
    end
    // A count write beats its own tick and hides the match after it.
    v = 8'h80 | 8'($random(seed));
    bus_wr(`TMR_ADR_CMPA, v);
    bus_wr(`TMR_ADR_FLAGS, 8'h07);
    bus_wr(`TMR_ADR_CTLB, 8'h01);
    bus_wr(`TMR_ADR_COUNT, v);
    bus_wr(`TMR_ADR_CTLB, 8'h00);
    idle(1);
    rchk(`TMR_ADR_COUNT, v + 8'h01);
    rchk(`TMR_ADR_FLAGS, {7'h00, v == 8'hff});
    // Buffered compare value waits for the top in fast PWM.
    bus_wr(`TMR_ADR_CMPA, 8'h40);
    bus_wr(`TMR_ADR_CTLA, 8'h03);
    bus_wr(`TMR_ADR_CMPA, 8'h10);
    rchk(`TMR_ADR_CMPA, 8'h10);
    bus_wr(`TMR_ADR_COUNT, 8'h05);
    bus_wr(`TMR_ADR_FLAGS, 8'h07);
    run(8'h01, 20);
    bus_rd(`TMR_ADR_FLAGS, r);
    chk(r[1], 1'b0);
    bus_wr(`TMR_ADR_COUNT, 8'hf0);
    bus_wr(`TMR_ADR_FLAGS, 8'h07);
    run(8'h01, 40);
    bus_rd(`TMR_ADR_FLAGS, r);
    chk(r[1], 1'b1);
    // Phase correct: buffered value A loads at top, sets on the down match.
    bus_wr(`TMR_ADR_CTLA, 8'h80);
    bus_wr(`TMR_ADR_CTLC, 8'h80);
    bus_wr(`TMR_ADR_CTLA, 8'h81);
    bus_wr(`TMR_ADR_CMPA, 8'hfc);
    bus_wr(`TMR_ADR_COUNT, 8'hfa);
    bus_wr(`TMR_ADR_FLAGS, 8'h07);
    run(8'h01, 9);
    rchk(`TMR_ADR_COUNT, 8'hfb);
    bus_rd(`TMR_ADR_FLAGS, r);
    chk(r, 8'h02);
    chk(oa, 1'b1);
    // Every tick source over about four tick periods.
    bus_wr(`TMR_ADR_CTLA, 8'h00);
    pin_en <= 1'b1;
    for (int s = 1; s < 8; s++) begin
      bus_wr(`TMR_ADR_COUNT, 8'h00);
      run({5'h0, s[2:0]}, 4 * div(s));
      bus_rd(`TMR_ADR_COUNT, r);
      chk(r >= 8'h03 && r <= 8'h05, 1'b1);
    end
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== dv/tmr_pin_model.sv
// Purpose: Drives the external count pin as a steady square wave.
// Assumes: The pin changes only just after a rising clock edge.
// Notes:   The pin rests low while the model is disabled.
`timescale 1ns/10ps
`default_nettype none
module tmr_pin_model #(
  parameter int HALF = 4
) (
  input  wire logic ref_clk_i,
  input  wire logic en_i,
  output logic      pin_o
);
  int cnt_r;
  initial begin
    cnt_r = 0;
    pin_o = 1'b0;
  end
  // Toggle the pin every HALF cycles while enabled.
  always @(posedge ref_clk_i) begin
    if (!en_i) begin
      cnt_r <= 0;
      pin_o <= 1'b0;
    end else if (cnt_r == HALF - 1) begin
      cnt_r <= 0;
      pin_o <= ~pin_o;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/tmr_cmp.sv
// Purpose: One compare unit: buffer, active compare value and output state.
// Assumes: Events arrive as one-cycle pulses from the core.
// Notes:   The output state survives mode changes.
`timescale 1ns/10ps
`default_nettype none
`include "tmr_defs.svh"
module tmr_cmp (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       dbuf_i,
  input  wire logic       load_i,
  input  wire logic [7:0] count_i,
  input  wire logic       hit_i,
  input  wire logic       bot_i,
  input  wire logic       fast_i,
  input  wire logic       pc_i,
  input  wire logic       down_i,
  input  wire logic       tog_ok_i,
  input  wire logic       force_i,
  input  wire logic [1:0] com_i,
  output logic [7:0]      act_o,
  output logic [7:0]      rd_o,
  output logic            match_o,
  output logic            oc_o
);
  logic [7:0] buf_r;
  logic       oc_nxt;

  // Buffer takes every write; active value direct or loaded from the buffer at top.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      buf_r <= `TMR_RST8;
      act_o <= `TMR_RST8;
    end else begin
      if (wr_i)
        buf_r <= wdata_i;
      if (wr_i && !dbuf_i)
        act_o <= wdata_i;
      else if (load_i)
        act_o <= buf_r;
    end
  end

  assign match_o = (count_i == act_o);
  assign rd_o    = dbuf_i ? buf_r : act_o;

  // Output action per mode; compare mode zero leaves the state alone.
  // mode zero idle.
  always_comb begin
    oc_nxt = oc_o;
    if (!fast_i && !pc_i) begin
      if (hit_i || force_i) begin
        case (com_i)
          2'h1:    oc_nxt = ~oc_o;
          2'h2:    oc_nxt = 1'b0;
          2'h3:    oc_nxt = 1'b1;
          default: oc_nxt = oc_o;
        endcase
      end
    end else if (hit_i) begin
      case (com_i)
        2'h1:    oc_nxt = tog_ok_i ? ~oc_o : oc_o;
        2'h2:    oc_nxt = pc_i & down_i;
        2'h3:    oc_nxt = ~(pc_i & down_i);
        default: oc_nxt = oc_o;
      endcase
    end else if (fast_i && bot_i) begin
      case (com_i)
        2'h2:    oc_nxt = 1'b1;
        2'h3:    oc_nxt = 1'b0;
        default: oc_nxt = oc_o;
      endcase
    end
  end

  // Output state register.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i)
      oc_o <= 1'b0;
    else
      oc_o <= oc_nxt;
  end
endmodule
`default_nettype wire

// ===== hdl/tmr_core.sv
// Purpose: 8-bit timer/counter with two compare units and a register port.
// Assumes: One clock; register reads answer in the following cycle.
// Notes:   Interrupt lines are flag AND mask; service acks clear flags.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "tmr_defs.svh"
// Behaviour
// - Count zero is bottom; a bottom indication is raised there.
// - All-ones, 255, is the maximum count.
// - Top is the maximum or compare value A, chosen by mode.
// - Tick from prescaled clock or count pin edge, by 3-bit select.
// - Select zero gives no tick; counter stays stopped.
// - Software reads and writes the count at any time.
// - A count write beats clear, increment or decrement that cycle.
// - Each tick clears, increments or decrements per the 3-bit mode.
// - Overflow flag set where the mode says; it can interrupt.
// - Compare always; matching flag set on the tick of equality.
// - Compare flags clear on service or on writing one.
// - Three sources, each masked, all visible in the flag register.
// - PWM modes buffer compare writes; transfer at top or bottom. The code transfers at top only.
// - Normal and clear-on-match modes write compare values directly.
// - Force strobe acts like a match on the output, no flag; the code ignores it in PWM modes.
// - A count write suppresses matches in the next tick.
// - Output formed from match, mode, output mode and extremes.
// - Mode zero counts up, wraps, overflow when count becomes zero.
// - Mode two clears the count on a match with value A.
// - Modes three and seven count bottom to top and restart.
// - Output mode zero leaves the output state alone.
module tmr_core
  import tmr_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  input  wire tmr_bus_s   bus_i,
  input  wire logic       external_count_pin_i,
  input  wire logic [2:0] irq_ack_i,
  output logic [7:0]      rdata_o,
  output logic [2:0]      irq_o,
  output logic            compare_output_a_o,
  output logic            compare_output_b_o
);
  logic [7:0] timer_control_a_r;
  logic [7:0] timer_control_b_r;
  logic [7:0] count_value_r;
  logic [7:0] count_value_nxt;
  logic [2:0] timer_mask_register_r;
  logic [2:0] timer_flag_register_r;
  logic [2:0] flags_nxt;
  logic       block_r;
  logic       down_r;
  logic       down_nxt;
  logic       timer_tick;
  tmr_wgm_e   waveform_mode_field;
  logic       fast;
  logic       pc;
  logic       ctc;
  logic       pwm;
  logic       top_is_a;
  logic [7:0] top_val;
  logic       at_top;
  logic       at_bottom;
  logic       at_max;
  logic       wr_count;
  logic       wr_flags;
  logic       wr_ctlc;
  logic       load;
  logic       ovf_set;
  logic [1:0] wr_cmp;
  logic [1:0] hit;
  logic [1:0] match;
  logic [1:0] force_compare_strobe;
  logic [1:0] oc;
  logic [7:0] cmp_act [2];
  logic [7:0] cmp_rd  [2];

  // Write decodes.
  assign wr_count = bus_i.wr && (bus_i.addr == `TMR_ADR_COUNT);
  assign wr_flags = bus_i.wr && (bus_i.addr == `TMR_ADR_FLAGS);
  assign wr_ctlc  = bus_i.wr && (bus_i.addr == `TMR_ADR_CTLC);
  assign wr_cmp[0] = bus_i.wr && (bus_i.addr == `TMR_ADR_CMPA);
  assign wr_cmp[1] = bus_i.wr && (bus_i.addr == `TMR_ADR_CMPB);

  // Control and mask registers.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      timer_control_a_r     <= `TMR_RST8;
      timer_control_b_r     <= `TMR_RST8;
      timer_mask_register_r <= `TMR_RST3;
    end else if (bus_i.wr) begin
      case (bus_i.addr)
        `TMR_ADR_CTLA: timer_control_a_r <= bus_i.wdata;
        `TMR_ADR_CTLB: timer_control_b_r <= bus_i.wdata;
        `TMR_ADR_MASK: timer_mask_register_r <= bus_i.wdata[2:0];
        default:       timer_control_a_r <= timer_control_a_r;
      endcase
    end
  end

  // mode field split over control A and B.
  assign waveform_mode_field = tmr_wgm_e'({
    timer_control_b_r[`TMR_WGM2_BIT],
    timer_control_a_r[`TMR_WGM_LO_HI:0]});

  // Mode class decode.
  always_comb begin
    fast     = 1'b0;
    pc       = 1'b0;
    ctc      = 1'b0;
    top_is_a = 1'b0;
    case (waveform_mode_field)
      TMR_WGM_FAST_MAX:  fast = 1'b1;
      TMR_WGM_FAST_CMPA: begin
        fast     = 1'b1;
        top_is_a = 1'b1;
      end
      TMR_WGM_PC_MAX:    pc = 1'b1;
      TMR_WGM_PC_CMPA:   begin
        pc       = 1'b1;
        top_is_a = 1'b1;
      end
      TMR_WGM_CTC:       begin
        ctc      = 1'b1;
        top_is_a = 1'b1;
      end
      default:           fast = 1'b0;
    endcase
  end
  assign pwm = fast | pc;

  assign top_val   = top_is_a ? cmp_act[0] : `TMR_MAX;
  assign at_top    = (count_value_r == top_val);
  assign at_bottom = (count_value_r == `TMR_BOTTOM);
  assign at_max    = (count_value_r == `TMR_MAX);

  tmr_tick #(
    .PW (`TMR_TAP1024)
  ) u_tick (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .sel_i     (timer_control_b_r[`TMR_CS_HI:0]),
    .pin_i     (external_count_pin_i),
    .tick_o    (timer_tick)
  );

  // Next count per mode; up/down direction in dual-slope modes.
  always_comb begin
    count_value_nxt = count_value_r;
    down_nxt        = down_r;
    if (wr_count) begin
      count_value_nxt = bus_i.wdata;
    end else if (timer_tick) begin
      if (fast) begin
        count_value_nxt = at_top ? `TMR_BOTTOM
                                 : count_value_r + `TMR_ONE;
      end else if (ctc) begin
        count_value_nxt = hit[0] ? `TMR_BOTTOM
                                 : count_value_r + `TMR_ONE;
      end else if (pc) begin
        if (down_r && at_bottom) begin
          down_nxt        = 1'b0;
          count_value_nxt = count_value_r + `TMR_ONE;
        end else if (!down_r && at_top) begin
          down_nxt        = 1'b1;
          count_value_nxt = count_value_r - `TMR_ONE;
        end else if (down_r) begin
          count_value_nxt = count_value_r - `TMR_ONE;
        end else begin
          count_value_nxt = count_value_r + `TMR_ONE;
        end
      end else begin
        count_value_nxt = count_value_r + `TMR_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      count_value_r <= `TMR_RST8;
      down_r        <= 1'b0;
    end else begin
      count_value_r <= count_value_nxt;
      down_r        <= down_nxt;
    end
  end

  // block matches after a count write.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i)
      block_r <= 1'b0;
    else if (wr_count)
      block_r <= 1'b1;
    else if (timer_tick)
      block_r <= 1'b0;
  end

  // buffer transfer at the end of the sequence.
  assign load = timer_tick && at_top && pwm && !wr_count;

  assign ovf_set = timer_tick && !wr_count &&
                   (fast ? at_top :
                    pc   ? (down_r && at_bottom) : at_max);

  // Compare units; PWM modes double buffer, others write directly.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cmp
      // flag event on a tick with equality.
      assign hit[gi] = timer_tick && match[gi] && !block_r;
      assign force_compare_strobe[gi] = wr_ctlc && !pwm &&
        bus_i.wdata[`TMR_FOCA_BIT - gi];
      // output from match, mode and extremes.
      tmr_cmp u_cmp (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .wr_i      (wr_cmp[gi]),
        .wdata_i   (bus_i.wdata),
        .dbuf_i    (pwm),
        .load_i    (load),
        .count_i   (count_value_r),
        .hit_i     (hit[gi]),
        .bot_i     (load && fast),
        .fast_i    (fast),
        .pc_i      (pc),
        .down_i    (down_r),
        .tog_ok_i  ((gi == 0) && top_is_a),
        .force_i   (force_compare_strobe[gi]),
        .com_i     (timer_control_a_r[`TMR_COMA_HI - 2*gi -: 2]),
        .act_o     (cmp_act[gi]),
        .rd_o      (cmp_rd[gi]),
        .match_o   (match[gi]),
        .oc_o      (oc[gi])
      );
    end
  endgenerate

  assign compare_output_a_o = oc[0];
  assign compare_output_b_o = oc[1];

  // Flags: set wins over clear; writing zero leaves a flag alone.
  always_comb begin
    // clear by one or by service.
    flags_nxt = timer_flag_register_r &
                ~((wr_flags ? bus_i.wdata[2:0] : 3'h0) | irq_ack_i);
    flags_nxt[`TMR_F_OVF]  = flags_nxt[`TMR_F_OVF]  | ovf_set;
    flags_nxt[`TMR_F_CMPA] = flags_nxt[`TMR_F_CMPA] | hit[0];
    flags_nxt[`TMR_F_CMPB] = flags_nxt[`TMR_F_CMPB] | hit[1];
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i)
      timer_flag_register_r <= `TMR_RST3;
    else
      timer_flag_register_r <= flags_nxt;
  end

  assign irq_o = timer_flag_register_r & timer_mask_register_r;

  // Read data stands one cycle after the read strobe, zero otherwise.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || !bus_i.rd) begin
      rdata_o <= `TMR_RST8;
    end else begin
      case (bus_i.addr)
        `TMR_ADR_CTLA:  rdata_o <= timer_control_a_r;
        `TMR_ADR_CTLB:  rdata_o <= timer_control_b_r;
        `TMR_ADR_CTLC:  rdata_o <= `TMR_RST8;
        `TMR_ADR_COUNT: rdata_o <= count_value_r;
        `TMR_ADR_CMPA:  rdata_o <= cmp_rd[0];
        `TMR_ADR_CMPB:  rdata_o <= cmp_rd[1];
        `TMR_ADR_MASK:  rdata_o <= {5'h00, timer_mask_register_r};
        `TMR_ADR_FLAGS: rdata_o <= {5'h00, timer_flag_register_r};
        default:        rdata_o <= `TMR_RST8;
      endcase
    end
  end

  // Checks on the timer behaviour.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_cnt_wr_prio: assert property (
    wr_count |=> count_value_r == $past(bus_i.wdata))
    else $error("Count write lost.");

  a_stop_hold: assert property (
    timer_control_b_r[`TMR_CS_HI:0] == `TMR_CS_OFF && !wr_count
    |=> $stable(count_value_r))
    else $error("Counter moved while stopped.");

  a_norm_ovf: assert property (
    waveform_mode_field == TMR_WGM_NORMAL && timer_tick && at_max &&
    !wr_count |=> count_value_r == `TMR_BOTTOM &&
    timer_flag_register_r[`TMR_F_OVF])
    else $error("Normal wrap without overflow flag.");

  a_ctc_clear: assert property (
    ctc && hit[0] && !wr_count |=> count_value_r == `TMR_BOTTOM)
    else $error("Match A did not clear the count.");

  a_fast_wrap: assert property (
    fast && timer_tick && at_top && !wr_count
    |=> count_value_r == `TMR_BOTTOM)
    else $error("Single slope did not restart.");

  a_cmp_flag: assert property (
    hit[1] |=> timer_flag_register_r[`TMR_F_CMPB])
    else $error("Compare B flag not set.");

  a_blk_match: assert property (
    wr_count ##1 (timer_tick && !timer_flag_register_r[`TMR_F_CMPA])
    |=> !timer_flag_register_r[`TMR_F_CMPA])
    else $error("Match not blocked after count write.");

  a_w1c_clear: assert property (
    wr_flags && bus_i.wdata[`TMR_F_CMPA] && !hit[0]
    |=> !timer_flag_register_r[`TMR_F_CMPA])
    else $error("Flag not cleared by writing one.");

  a_w0_keep: assert property (
    wr_flags && !bus_i.wdata[`TMR_F_OVF] && !irq_ack_i[`TMR_F_OVF]
    |=> timer_flag_register_r[`TMR_F_OVF] >=
        $past(timer_flag_register_r[`TMR_F_OVF]))
    else $error("Writing zero cleared a flag.");

  a_dbuf_hold: assert property (
    pwm && wr_cmp[0] && !load |=> cmp_act[0] == $past(cmp_act[0]))
    else $error("PWM compare write bypassed the buffer.");

  a_foc_read: assert property (
    bus_i.rd && bus_i.addr == `TMR_ADR_CTLC |=> rdata_o == `TMR_RST8)
    else $error("Force strobes read back nonzero.");
endmodule
`default_nettype wire

// ===== hdl/tmr_defs.svh
// Purpose: Register offsets, field positions and counts for the timer core.
// Assumes: An 8-bit register port with a 3-bit word address.
// Notes:   Definitions only; included by bare name.
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
// Register offsets.
`define TMR_ADR_CTLA   3'h0
`define TMR_ADR_CTLB   3'h1
`define TMR_ADR_CTLC   3'h2
`define TMR_ADR_COUNT  3'h3
`define TMR_ADR_CMPA   3'h4
`define TMR_ADR_CMPB   3'h5
`define TMR_ADR_MASK   3'h6
`define TMR_ADR_FLAGS  3'h7
// Field positions.
`define TMR_COMA_HI    7
`define TMR_WGM_LO_HI  1
`define TMR_WGM2_BIT   3
`define TMR_CS_HI      2
`define TMR_FOCA_BIT   7
`define TMR_F_OVF      0
`define TMR_F_CMPA     1
`define TMR_F_CMPB     2
// Count range and reset values.
`define TMR_BOTTOM     8'h00
`define TMR_MAX        8'hff
`define TMR_ONE        8'h01
`define TMR_RST8       8'h00
`define TMR_RST3       3'h0
// Clock select codes and prescaler tap widths.
`define TMR_CS_OFF     3'h0
`define TMR_CS_DIV1    3'h1
`define TMR_CS_DIV8    3'h2
`define TMR_CS_DIV64   3'h3
`define TMR_CS_DIV256  3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_CS_EXTFALL 3'h6
`define TMR_CS_EXTRISE 3'h7
`define TMR_TAP8       3
`define TMR_TAP64      6
`define TMR_TAP256     8
`define TMR_TAP1024    10
`endif

// ===== hdl/tmr_pkg.sv
// Purpose: Types shared by the timer core files.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   Constants live in tmr_defs.svh.
package tmr_pkg;
  // Waveform modes; 4 and 6 are reserved and run as normal mode.
  typedef enum logic [2:0] {
    TMR_WGM_NORMAL   = 3'b000,
    TMR_WGM_PC_MAX   = 3'b001,
    TMR_WGM_CTC      = 3'b010,
    TMR_WGM_FAST_MAX = 3'b011,
    TMR_WGM_RSV4     = 3'b100,
    TMR_WGM_PC_CMPA  = 3'b101,
    TMR_WGM_RSV6     = 3'b110,
    TMR_WGM_FAST_CMPA = 3'b111
  } tmr_wgm_e;
  // One register port request.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmr_bus_s;
endpackage

// ===== hdl/tmr_tick.sv
// Purpose: Timer tick source: prescaled clock or edge of the count pin.
// Assumes: The count pin is synchronous to ref_clk_i.
// Notes:   Tick is a one-cycle pulse; select 1 holds it high every cycle.
`timescale 1ns/10ps
`default_nettype none
`include "tmr_defs.svh"
module tmr_tick #(
  parameter int PW = `TMR_TAP1024
) (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [2:0] sel_i,
  input  wire logic       pin_i,
  output logic            tick_o
);
  logic [PW-1:0] pre_r;
  logic          pin_r;

  // Free-running prescaler and previous pin level.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      pre_r <= '0;
      pin_r <= 1'b0;
    end else begin
      pre_r <= pre_r + 1'b1;
      pin_r <= pin_i;
    end
  end

  // Select the tick source; code zero stops the timer.
  always_comb begin
    case (sel_i)
      `TMR_CS_OFF:     tick_o = 1'b0;
      `TMR_CS_DIV1:    tick_o = 1'b1;
      `TMR_CS_DIV8:    tick_o = &pre_r[`TMR_TAP8-1:0];
      `TMR_CS_DIV64:   tick_o = &pre_r[`TMR_TAP64-1:0];
      `TMR_CS_DIV256:  tick_o = &pre_r[`TMR_TAP256-1:0];
      `TMR_CS_DIV1024: tick_o = &pre_r[`TMR_TAP1024-1:0];
      `TMR_CS_EXTFALL: tick_o = pin_r & ~pin_i;
      `TMR_CS_EXTRISE: tick_o = ~pin_r & pin_i;
      default:         tick_o = 1'b0;
    endcase
  end
endmodule
`default_nettype wire
